//--- logic/bsd_pkg.sv
// constants shared by the buck set-point and scaling control block
// Function
// (RULE1) buck5 over-current: limit cycle by cycle, set fault flag, raise short-circuit interrupt.
// (RULE2) buck5 five-bit code is linear, 25 mV steps, 00000 = 1.2000 V up to 11010.
// (RULE3) host should force buck5 into PWM mode before changing its set point.
// (RULE4) bucks 1 and 2 use normal field when standby is 0, standby field when 1.
// (RULE5) a write to a normal set-point field starts a stepped, rate-limited transition.
// (RULE6) standby transitions on bucks 1, 2 step every 2, 4, 8 or 16 us; default 01.
// (RULE7) host changes on bucks 3 and 5 step 25 mV every 4.0 us to target.
// (RULE8) buck4 pair steps every 8.0 us with range 00, otherwise every 16 us.
// (RULE9) bucks 3, 4 and 5 also hold a standby set point used during standby.
// (RULE10) bucks 1 and 2 drive active-high power-good only once output reached its target.
// (RULE11) power-good is low during a whole scaling transition and while at current limit.
// (RULE12) over-current seen during a scaling transition is masked, not reported as a fault.
// (RULE13) current limit outside a transition keeps power-good low until the limit clears.
// (RULE14) sequencer steps once per interval, stops when equal, restarts if target moves.
package bsd_pkg;
  // =====================================================================
  // clock and step timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int BASE_STEP_NS  = 2000;   // fastest interval, 2.0 us
  localparam int B35_STEP_NS   = 4000;   // buck3 and buck5, 4.0 us
  localparam int B4LO_STEP_NS  = 8000;   // buck4 range 00, 8.0 us
  localparam int B4HI_STEP_NS  = 16000;  // buck4 other range, 16 us
  localparam int BASE_TICK_CYC = (BASE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] B35_TICKS  = 4'(B35_STEP_NS / BASE_STEP_NS);
  localparam logic [3:0] B4LO_TICKS = 4'(B4LO_STEP_NS / BASE_STEP_NS);
  localparam logic [3:0] B4HI_TICKS = 4'(B4HI_STEP_NS / BASE_STEP_NS);
  // =====================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] BUCK_CFG_BASE = 8'h00;  // one word per buck, 0x00..0x10
  localparam logic [7:0] STATUS_OFS    = 8'h14;
  localparam logic [7:0] MASK_OFS      = 8'h18;
  localparam logic [7:0] STATE_OFS     = 8'h1c;
  // =====================================================================
  // field layout of a buck config word
  localparam int NRM_LSB   = 0;
  localparam int STB_LSB   = 8;
  localparam int SPD_LSB   = 16;
  localparam int CODE_W    = 6;
  localparam int NBUCK     = 5;
  localparam logic [1:0] SPEED_RST = 2'h1;
  localparam logic [1:0] RANGE_RST = 2'h0;
  localparam logic [5:0] CODE_RST  = 6'h00;
  // status bit positions
  localparam int ST_OC5    = 0;
  // =====================================================================
  // buck5 code decode
  localparam logic [5:0]  B5_MAX_CODE = 6'h1a;
  localparam logic [11:0] B5_BASE_MV  = 12'd1200;
  localparam logic [11:0] B5_STEP_MV  = 12'd25;
endpackage

//--- logic/bsd_stepper.sv
// one set-point stepping sequencer, one code per interval toward target
`timescale 1ns/1ps
`default_nettype none
module bsd_stepper #(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // step timing
  input  wire logic         tick,
  input  wire logic [3:0]   interval,
  // set points
  input  wire logic [W-1:0] target,
  output var  logic [W-1:0] level,
  output var  logic         busy
);
  logic [W-1:0] level_r;
  logic [W-1:0] tgt_q_r;
  logic [3:0]   cnt_r;
  wire          moved    = (target != tgt_q_r);
  wire          due      = tick && ((cnt_r + 4'h1) >= interval);
  wire          go_up    = (target > level_r);
  wire [W-1:0]  level_nxt = go_up ? W'(level_r + 1'b1) : W'(level_r - 1'b1);

  // elaboration check: the step logic needs at least one code bit
  if (W < 1) begin : g_bad_w
    $error("W out of range");
  end

  assign level = level_r;
  assign busy  = (level_r != target);

  // =====================================================================
  // sequencer: a moved target restarts the interval from the current level
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      level_r <= '0;
      tgt_q_r <= '0;
      cnt_r   <= 4'h0;
    end else begin
      tgt_q_r <= target;
      if (moved || !busy) begin
        cnt_r <= 4'h0;  // RULE14
      end else if (due) begin
        level_r <= level_nxt;  // RULE5 RULE14
        cnt_r   <= 4'h0;
      end else if (tick) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // =====================================================================
  // checks
  chk_step_one_code: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE14
    $changed(level_r) |-> ((level_r == $past(level_r) + W'(1))
                        || (level_r == $past(level_r) - W'(1))))
    else $error("level moved by more than one code");
  chk_idle_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE14
    (!busy && !moved) |=> $stable(level_r))
    else $error("level moved while at target");
  chk_restart_cnt: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE14
    moved |=> (cnt_r == 4'h0))
    else $error("interval not restarted on target change");
endmodule // bsd_stepper
`default_nettype wire

//--- logic/bsd_top.sv
// buck set-point selection, scaling step timing, power-good and fault logic
`timescale 1ns/1ps
`default_nettype none
module bsd_top #(
  parameter int TICK_CYC = bsd_pkg::BASE_TICK_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // regulator side
  input  wire logic        standby,
  input  wire logic [4:0]  current_limit,
  output logic [5:0]       buck1_level,
  output logic [5:0]       buck2_level,
  output logic [5:0]       buck3_level,
  output logic [5:0]       buck4_level,
  output logic [4:0]       buck5_setpoint_code,
  output logic [11:0]      buck5_millivolts,
  output logic             buck5_cycle_limit,
  // to processor
  output logic [1:0]       power_good_output,
  output logic             short_circuit_interrupt
);
  localparam int NB = bsd_pkg::NBUCK;
  localparam int CW = bsd_pkg::CODE_W;

  // elaboration check: tick period must fit the 16-bit divider
  if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_bad_tick
    $error("TICK_CYC out of range");
  end

  // elaboration check: decode, read mux and buck5 saturation assume five six-bit bucks
  if (NB != 5 || CW != 6) begin : g_bad_shape
    $error("bucks or code width not supported");
  end

  // =====================================================================
  // registers
  logic [CW-1:0] normal_setpoint_field  [NB];
  logic [CW-1:0] standby_setpoint_field [NB];
  logic [1:0]    scaling_speed_field    [2];
  logic [1:0]    buck4_range_field;
  logic [0:0]    status_r;
  logic [0:0]    mask_r;
  logic [15:0]   div_r;
  logic          tick_r;
  logic          dph_wr_r;
  logic          dph_rd_r;
  logic [7:0]    dph_addr_r;

  // =====================================================================
  // ahb decode: take in the address phase, selects from the registered data phase address
  wire        take      = hsel && htrans[1] && hready;
  wire        cfg_hit   = (dph_addr_r < bsd_pkg::STATUS_OFS);
  wire [2:0]  cfg_idx   = dph_addr_r[4:2];
  wire        wr_cfg    = dph_wr_r && cfg_hit;
  wire        wr_mask   = dph_wr_r && (dph_addr_r == bsd_pkg::MASK_OFS);
  wire        rd_status = dph_rd_r && (dph_addr_r == bsd_pkg::STATUS_OFS);
  wire [5:0]  wr_nrm    = hwdata[bsd_pkg::NRM_LSB +: CW];
  wire [5:0]  wr_stb    = hwdata[bsd_pkg::STB_LSB +: CW];
  wire [1:0]  wr_spd    = hwdata[bsd_pkg::SPD_LSB +: 2];

  // buck5 codes above the top listed value saturate
  wire [5:0]  nrm5      = {1'b0, wr_nrm[4:0]};
  wire [5:0]  stb5      = {1'b0, wr_stb[4:0]};
  wire [5:0]  nrm5_sat  = (nrm5 > bsd_pkg::B5_MAX_CODE) ? bsd_pkg::B5_MAX_CODE : nrm5;  // RULE2
  wire [5:0]  stb5_sat  = (stb5 > bsd_pkg::B5_MAX_CODE) ? bsd_pkg::B5_MAX_CODE : stb5;  // RULE2

  // =====================================================================
  // stepping sequencers, one per buck
  logic [CW-1:0] tgt   [NB];
  logic [3:0]    intv  [NB];
  logic [CW-1:0] lvl   [NB];
  logic [NB-1:0] busy;

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_buck
      // standby input picks which stored set point is the target
      assign tgt[gi] = standby ? standby_setpoint_field[gi]   // RULE4 RULE9
                               : normal_setpoint_field[gi];
      if (gi < 2) begin : g_dvs
        assign intv[gi] = 4'h1 << scaling_speed_field[gi];     // RULE6
      end else if (gi == 3) begin : g_b4
        assign intv[gi] = (buck4_range_field == 2'h0) ? bsd_pkg::B4LO_TICKS  // RULE8
                                                      : bsd_pkg::B4HI_TICKS;
      end else begin : g_b35
        assign intv[gi] = bsd_pkg::B35_TICKS;                  // RULE7
      end
      bsd_stepper #(.W(CW)) u_step (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .tick     (tick_r),
        .interval (intv[gi]),
        .target   (tgt[gi]),
        .level    (lvl[gi]),
        .busy     (busy[gi])
      );

      // config word writes
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          normal_setpoint_field[gi]  <= bsd_pkg::CODE_RST;
          standby_setpoint_field[gi] <= bsd_pkg::CODE_RST;
        end else if (wr_cfg && cfg_idx == 3'(gi)) begin
          normal_setpoint_field[gi]  <= (gi == 4) ? nrm5_sat : wr_nrm;  // RULE5
          standby_setpoint_field[gi] <= (gi == 4) ? stb5_sat : wr_stb;  // RULE9
        end
      end
    end
  endgenerate

  // =====================================================================
  // speed and range fields
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scaling_speed_field[0] <= bsd_pkg::SPEED_RST;  // RULE6
      scaling_speed_field[1] <= bsd_pkg::SPEED_RST;
      buck4_range_field      <= bsd_pkg::RANGE_RST;
    end else if (wr_cfg) begin
      if (cfg_idx == 3'h0) scaling_speed_field[0] <= wr_spd;
      if (cfg_idx == 3'h1) scaling_speed_field[1] <= wr_spd;
      if (cfg_idx == 3'h3) buck4_range_field      <= wr_spd;
    end
  end

  // =====================================================================
  // base step tick every 2.0 us
  wire tick_due = (div_r == 16'(TICK_CYC - 1));
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      div_r  <= tick_due ? 16'h0000 : div_r + 16'h0001;
      tick_r <= tick_due;
    end
  end

  // =====================================================================
  // fault flag and interrupt; masked while buck5 is scaling
  wire oc5_event = current_limit[4] && !busy[4];          // RULE1 RULE12
  wire [0:0] status_nxt = oc5_event ? 1'b1                 // set beats clear
                        : (rd_status ? 1'b0 : status_r[0]);
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status_r                <= 1'b0;
      mask_r                  <= 1'b0;
      short_circuit_interrupt <= 1'b0;
      buck5_cycle_limit       <= 1'b0;
    end else begin
      status_r                <= status_nxt;               // RULE1
      if (wr_mask) mask_r     <= hwdata[bsd_pkg::ST_OC5];
      short_circuit_interrupt <= |(status_nxt & mask_r);   // RULE1
      buck5_cycle_limit       <= current_limit[4];         // RULE1
    end
  end

  // =====================================================================
  // power-good: only at target and not limiting
  wire [1:0] pg_nxt = ~busy[1:0] & ~current_limit[1:0];   // RULE10 RULE11 RULE13
  always_ff @(posedge ref_clk) begin
    if (sys_rst) power_good_output <= 2'b00;
    else         power_good_output <= pg_nxt;
  end

  // =====================================================================
  // level outputs; buck5 code decode to millivolts
  wire [11:0] b5_mv = bsd_pkg::B5_BASE_MV + 12'(bsd_pkg::B5_STEP_MV * 12'(lvl[4]));  // RULE2
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      buck1_level         <= 6'h00;
      buck2_level         <= 6'h00;
      buck3_level         <= 6'h00;
      buck4_level         <= 6'h00;
      buck5_setpoint_code <= 5'h00;
      buck5_millivolts    <= bsd_pkg::B5_BASE_MV;
    end else begin
      buck1_level         <= lvl[0];
      buck2_level         <= lvl[1];
      buck3_level         <= lvl[2];
      buck4_level         <= lvl[3];
      buck5_setpoint_code <= lvl[4][4:0];
      buck5_millivolts    <= b5_mv;
    end
  end

  // =====================================================================
  // ahb read mux; unmapped reads return zero
  wire [31:0] cfg_word = {14'h0000,
                          (cfg_idx == 3'h0) ? scaling_speed_field[0] :
                          (cfg_idx == 3'h1) ? scaling_speed_field[1] :
                          (cfg_idx == 3'h3) ? buck4_range_field : 2'h0,
                          2'h0, standby_setpoint_field[cfg_idx],
                          2'h0, normal_setpoint_field[cfg_idx]};
  wire [31:0] state_word = {19'h00000, current_limit, standby, busy, power_good_output};
  wire [31:0] rd_word = cfg_hit                             ? cfg_word :
                        (dph_addr_r == bsd_pkg::STATUS_OFS) ? {31'h0, status_r} :
                        (dph_addr_r == bsd_pkg::MASK_OFS)   ? {31'h0, mask_r} :
                        (dph_addr_r == bsd_pkg::STATE_OFS)  ? state_word : 32'h0;

  // =====================================================================
  // ahb handshake: writes zero wait, reads one wait state so data is registered
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dph_wr_r   <= 1'b0;
      dph_rd_r   <= 1'b0;
      dph_addr_r <= 8'h00;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0;
    end else begin
      hresp <= 1'b0;
      if (dph_rd_r) begin
        hrdata    <= rd_word;
        hreadyout <= 1'b1;
        dph_rd_r  <= 1'b0;
      end else begin
        dph_wr_r   <= take && hwrite;
        dph_rd_r   <= take && !hwrite;
        hreadyout  <= !(take && !hwrite);
        if (take) dph_addr_r <= haddr[7:0];
      end
    end
  end

  // =====================================================================
  // checks
  logic [5:0] gap3_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst)                 gap3_r <= 6'h3f;
    else if (lvl[2] != buck3_level) gap3_r <= 6'h00;
    else if (gap3_r != 6'h3f)    gap3_r <= gap3_r + 6'h01;
  end

  chk_pg_scaling: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE11
    busy[0] |=> !power_good_output[0])
    else $error("power good high during scaling");
  chk_pg_limit_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE13
    current_limit[1] |=> !power_good_output[1])
    else $error("power good high during current limit");
  chk_pg_reached: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE10
    (!busy[0] && !current_limit[0]) |=> power_good_output[0])
    else $error("power good not high at target");
  chk_oc_flag_set: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
    (current_limit[4] && !busy[4] && mask_r[0]) |=> (status_r[0] && short_circuit_interrupt))
    else $error("over-current not flagged");
  chk_oc_masked: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE12
    (!status_r[0] && busy[4]) |=> !status_r[0])
    else $error("over-current reported during scaling");
  chk_standby_pick: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE4
    standby |-> (tgt[1] == standby_setpoint_field[1]))
    else $error("wrong set point selected in standby");
  chk_b5_decode: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
    1'b1 |=> (buck5_millivolts == 12'd1200 + 12'd25 * 12'($past(lvl[4]))))
    else $error("buck5 millivolt decode wrong");
  chk_b3_step_rate: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE7
    (lvl[2] != buck3_level) |-> (gap3_r >= 6'd39))
    else $error("buck3 stepped faster than 4 us");
  chk_tick_period: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE6
    tick_r |-> ##20 tick_r)
    else $error("base tick period wrong");

  // power-good on the other buck of the pair, scaling and limit; buck1 settling on its normal set point
  chk_pg_scaling_b2: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE11
    busy[1] |=> !power_good_output[1])
    else $error("buck2 power good high during scaling");
  chk_pg_limit_b1: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE13
    current_limit[0] |=> !power_good_output[0])
    else $error("buck1 power good high during current limit");
  chk_b1_settles: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE4
    (!standby && !busy[0]) |-> (lvl[0] == normal_setpoint_field[0]))
    else $error("buck1 settled away from its normal set point");

  // buck5 code range, fault flag and interrupt
  chk_b5_code_max: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
    {1'b0, buck5_setpoint_code} <= bsd_pkg::B5_MAX_CODE)
    else $error("buck5 code above the top listed value");
  chk_b5_target_cap: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE2
    (normal_setpoint_field[4] <= bsd_pkg::B5_MAX_CODE)
    && (standby_setpoint_field[4] <= bsd_pkg::B5_MAX_CODE))
    else $error("buck5 stored code not saturated");
  chk_int_level: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
    1'b1 |=> (short_circuit_interrupt == (status_r[0] && $past(mask_r[0]))))
    else $error("interrupt level disagrees with flag and mask");
  chk_oc_read_clear: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
    (rd_status && !oc5_event) |=> !status_r[0])
    else $error("status read did not clear the flag");
  chk_limit_copy: assert property (@(posedge ref_clk) disable iff (sys_rst) // RULE1
    1'b1 |=> (buck5_cycle_limit == $past(current_limit[4])))
    else $error("cycle limit command does not follow the limiter");

  // bus handshake: one wait state per read, response always okay
  chk_read_one_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (take && !hwrite && !dph_rd_r) |=> (!hreadyout ##1 hreadyout))
    else $error("read wait state not exactly one cycle");
  chk_hresp_okay: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !hresp)
    else $error("slave response not okay");
endmodule // bsd_top
`default_nettype wire

//--- verification/bsd_ahb_host.sv
// ahb-lite master model standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module bsd_ahb_host (
  // clock
  input  wire logic        ref_clk,
  // ahb-lite master side
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // read completion for the bench
  output logic             rd_done,
  output logic [31:0]      rd_data
);
  // =====================================================================
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_done = 1'b0;
    rd_data = 32'h0;
  end
  // completion flag lasts one cycle so the watcher pops once
  always @(posedge ref_clk) if (rd_done) rd_done <= 1'b0;
  // =====================================================================
  // one single word transfer; waits on hready as long as the slave asks
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= {24'h0, ~a};   // stale address must not look valid
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hwdata <= ~d;           // released data no longer shows the word
    if (!w) begin
      rd_data <= hrdata;
      rd_done <= 1'b1;
    end
  endtask
endmodule // bsd_ahb_host
`default_nettype wire

//--- verification/bsd_top_bench.sv
// self-checking bench for the buck set-point and scaling control block
`timescale 1ns/1ps
`default_nettype none
module bsd_top_bench;
  localparam int TK = 20;
  logic        ref_clk, sys_rst, standby, hsel, hwrite, hreadyout, hresp;
  logic        rd_done, buck5_cycle_limit, short_circuit_interrupt;
  logic [1:0]  htrans, power_good_output;
  logic [2:0]  hsize;
  logic [4:0]  current_limit, buck5_setpoint_code, c;
  logic [5:0]  buck1_level, buck2_level, buck3_level, buck4_level, e;
  logic [11:0] buck5_millivolts;
  logic [31:0] haddr, hwdata, hrdata, rd_data;
  logic [31:0] exp_q[$];
  int          fail_count, samples_checked, seed;
  // =====================================================================
  // clock, design and host model
  always #50 ref_clk = ~ref_clk;
  bsd_top #(.TICK_CYC(TK)) dut (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .standby,
    .current_limit, .buck1_level, .buck2_level, .buck3_level, .buck4_level,
    .buck5_setpoint_code, .buck5_millivolts, .buck5_cycle_limit, .power_good_output,
    .short_circuit_interrupt);
  bsd_ahb_host host (.ref_clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .rd_done, .rd_data);
  // =====================================================================
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  // the expectation is queued first; the watcher compares on completion
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    host.xfer(1'b0, a, 32'h0);
  endtask
  always @(posedge ref_clk) if (rd_done === 1'b1) check(rd_data, exp_q.pop_front());
  function automatic logic [5:0] lvl(input int b);
    case (b)
      0: return buck1_level;
      1: return buck2_level;
      2: return buck3_level;
      3: return buck4_level;
      default: return {1'b0, buck5_setpoint_code};
    endcase
  endfunction
  // follow one ramp: single code steps, fixed gap, power-good low meanwhile
  task automatic ramp(input int b, input logic [5:0] tgt, input int gap);
    logic [5:0] prev;
    int n;
    int first;
    prev = lvl(b);
    n = 0;
    first = 1;
    while (lvl(b) !== tgt) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 20 * TK) begin
        check(32'(n), 32'(gap));
        break;
      end
      if (lvl(b) !== prev) begin
        check(32'(lvl(b)), 32'(tgt > prev ? prev + 6'h1 : prev - 6'h1));
        if (!first) check(32'(n), 32'(gap));
        if (b < 2 && lvl(b) !== tgt) check({31'h0, power_good_output[b]}, 32'h0);
        prev = lvl(b);
        n = 0;
        first = 0;
      end
    end
  endtask
  task automatic pg_up(input int b);
    repeat (2) @(posedge ref_clk);
    #1;
    check({31'h0, power_good_output[b]}, 32'h1);
  endtask
  // =====================================================================
  // watchdog: the whole run needs roughly 9k cycles
  initial begin
    #4000000;
    fail_count++;
    summarize();
  end
  // =====================================================================
  // main sequence
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    standby = 1'b0;
    current_limit = 5'h00;
    fail_count = 0;
    samples_checked = 0;
    seed = 40267;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // reset values, unmapped place, state word
    wr(8'h24, 32'hffff_ffff);
    rd(8'h00, 32'h0001_0000);
    rd(8'h04, 32'h0001_0000);
    rd(8'h0c, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h1c, 32'h3);
    $display("test registers done");
    // fault flag, interrupt masking, read-to-clear
    wr(8'h18, 32'h1);
    @(posedge ref_clk) current_limit <= 5'h10;
    repeat (3) @(posedge ref_clk);
    #1;
    check({31'h0, short_circuit_interrupt}, 32'h1);
    check({31'h0, buck5_cycle_limit}, 32'h1);
    @(posedge ref_clk) current_limit <= 5'h00;
    rd(8'h14, 32'h1);
    rd(8'h14, 32'h0);
    #1;
    check({31'h0, short_circuit_interrupt}, 32'h0);
    wr(8'h18, 32'h0);
    @(posedge ref_clk) current_limit <= 5'h10;
    repeat (3) @(posedge ref_clk);
    #1;
    check({31'h0, short_circuit_interrupt}, 32'h0);
    @(posedge ref_clk) current_limit <= 5'h01;
    repeat (4) @(posedge ref_clk);
    #1;
    check({30'h0, power_good_output}, 32'h2);
    @(posedge ref_clk) current_limit <= 5'h02;
    repeat (4) @(posedge ref_clk);
    #1;
    check({30'h0, power_good_output}, 32'h1);
    @(posedge ref_clk) current_limit <= 5'h00;
    pg_up(0);
    pg_up(1);
    rd(8'h14, 32'h1);
    // limit during a buck5 ramp must not flag
    wr(8'h10, 32'h14);
    @(posedge ref_clk) current_limit <= 5'h10;
    repeat (3) @(posedge ref_clk);
    #1;
    check({31'h0, buck5_cycle_limit}, 32'h1);
    @(posedge ref_clk) current_limit <= 5'h00;
    rd(8'h14, 32'h0);
    ramp(4, 6'h14, 2 * TK);
    $display("test fault done");
    // buck5 codes: random, above the top code, and zero
    for (int k = 0; k < 4; k++) begin
      c = (k == 2) ? 5'h1f : (k == 3) ? 5'h00 : 5'($random(seed));
      e = (c > 5'h1a) ? 6'h1a : {1'b0, c};
      wr(8'h10, {27'h0, c});
      ramp(4, e, 2 * TK);
      @(posedge ref_clk);
      #1;
      check({20'h0, buck5_millivolts}, 32'(12'd1200 + 12'd25 * e));
    end
    $display("test buck5 done");
    // buck4 pair rates for both range settings
    wr(8'h0c, 32'h0000_0003);
    ramp(3, 6'h03, 4 * TK);
    wr(8'h0c, 32'h0001_0000);
    ramp(3, 6'h00, 8 * TK);
    $display("test buck4 done");
    // standby set points and every speed code, alternating between bucks 1 and 2
    for (int s = 0; s < 4; s++) begin
      wr(8'(4 * (s % 2)), (32'(s) << 16) | 32'h0800);
      @(posedge ref_clk) standby <= 1'b1;
      ramp(s % 2, 6'h08, (1 << s) * TK);
      pg_up(s % 2);
      @(posedge ref_clk) standby <= 1'b0;
      ramp(s % 2, 6'h00, (1 << s) * TK);
      pg_up(s % 2);
    end
    $display("test standby done");
    // buck3: target moved mid-ramp, then its standby set point
    wr(8'h08, 32'h0000_000a);
    repeat (12 * TK) @(posedge ref_clk);
    wr(8'h08, 32'h0000_0502);
    ramp(2, 6'h02, 2 * TK);
    @(posedge ref_clk) standby <= 1'b1;
    ramp(2, 6'h05, 2 * TK);
    @(posedge ref_clk) standby <= 1'b0;
    ramp(2, 6'h02, 2 * TK);
    $display("test buck3 done");
    summarize();
  end
endmodule // bsd_top_bench
`default_nettype wire
